// ==== ttsr_pkg.sv ====
// Shared constants and decoders for the interval timer two and serial shifter.
// Assumes a single system clock and an external register select of four bits.
package ttsr_pkg;

  // Register offsets on the register select lines
  localparam logic [3:0] TTSR_T2_LO_OFF  = 4'h8;
  localparam logic [3:0] TTSR_T2_HI_OFF  = 4'h9;
  localparam logic [3:0] TTSR_SHIFT_OFF  = 4'ha;

  // Values after reset, and the value timer two wraps to
  localparam logic [7:0]  TTSR_SHIFT_RST = 8'h00;
  localparam logic [7:0]  TTSR_LATCH_RST = 8'h00;
  localparam logic [15:0] TTSR_COUNT_RST = 16'h0000;
  localparam logic [15:0] TTSR_T2_WRAP   = 16'hffff;
  localparam logic [7:0]  TTSR_READ_NONE = 8'h00;

  // Bit counter: eight shifts per transfer
  localparam logic [2:0] TTSR_LAST_BIT  = 3'h7;
  localparam logic [2:0] TTSR_FIRST_BIT = 3'h0;

  // Shift modes from the three auxiliary control bits
  typedef enum logic [2:0] {
    TTSR_SM_OFF     = 3'h0,
    TTSR_SM_IN_T2   = 3'h1,
    TTSR_SM_IN_SYS  = 3'h2,
    TTSR_SM_IN_EXT  = 3'h3,
    TTSR_SM_OUT_FR  = 3'h4,
    TTSR_SM_OUT_T2  = 3'h5,
    TTSR_SM_OUT_SYS = 3'h6,
    TTSR_SM_OUT_EXT = 3'h7
  } ttsr_mode_e;

  // Shifter sequencer states, Gray coded along idle, wait, run
  typedef enum logic [1:0] {
    TTSR_ST_IDLE = 2'b00,
    TTSR_ST_WAIT = 2'b01,
    TTSR_ST_RUN  = 2'b11
  } ttsr_state_e;

  // Mode shifts data out on the data line
  function automatic logic ttsr_is_out(input logic [2:0] m);
    ttsr_is_out = m[2];
  endfunction

  // Mode takes its shift clock from the clock line
  function automatic logic ttsr_is_ext(input logic [2:0] m);
    ttsr_is_ext = (m[1:0] == 2'b11);
  endfunction

  // Mode paced by the timer two low latch
  function automatic logic ttsr_is_t2(input logic [2:0] m);
    ttsr_is_t2 = (m == TTSR_SM_IN_T2) || (m == TTSR_SM_OUT_FR) || (m == TTSR_SM_OUT_T2);
  endfunction

endpackage

// ==== ttsr_timer.sv ====
// Interval timer two: low latch, 16-bit down counter and its time-out flag.
// Assumes one-cycle write and read strobes already decoded by the parent.
`timescale 1ns/10ps
`default_nettype none
module ttsr_timer (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        pulse_mode,
  input  wire logic        pulse_count_input,
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic        rd_lo,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  latch_lo,
  output logic      [15:0] count,
  output logic             timer_two_flag
);

  logic armed_reg;
  logic pulse_prev_reg;
  logic dec;
  logic hit;

  // One decrement per cycle, or per falling pulse sampled low at the edge
  assign dec = pulse_mode ? (pulse_prev_reg & ~pulse_count_input) : 1'b1;
  assign hit = dec && (count == 16'h0001) && armed_reg && !wr_hi;

  // Low latch is loaded alone
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      latch_lo <= ttsr_pkg::TTSR_LATCH_RST;
    end else if (wr_lo) begin
      latch_lo <= wdata;
    end
  end

  // Counter: high write loads both halves, time-out wraps and keeps going
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count          <= ttsr_pkg::TTSR_COUNT_RST;
      pulse_prev_reg <= 1'b1;
    end else begin
      pulse_prev_reg <= pulse_count_input;
      if (wr_hi) begin
        count <= {wdata, latch_lo};
      end else if (dec) begin
        count <= count - 16'h0001;
      end
    end
  end

  // Flag logic armed by a high write, disarmed by the first zero count
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      armed_reg      <= 1'b0;
      timer_two_flag <= 1'b0;
    end else begin
      if (wr_hi) begin
        armed_reg <= 1'b1;
      end else if (hit) begin
        armed_reg <= 1'b0;
      end
      if (hit) begin
        timer_two_flag <= 1'b1;
      end else if (wr_hi || rd_lo) begin
        timer_two_flag <= 1'b0;
      end
    end
  end

  a_t2_wrap_ones: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!pulse_mode && count == 16'h0000 && !wr_hi) |=> count == 16'hffff)
    else $error("timer two did not wrap to all ones");
  a_t2_no_rearm: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!armed_reg && !wr_hi && !timer_two_flag) |=> !timer_two_flag)
    else $error("timer two flag set without re-arm");
  a_t2_hi_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_hi |=> !timer_two_flag ##0 count == $past({wdata, latch_lo}))
    else $error("high write did not clear flag and load counter");
  a_t2_sets_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    hit |=> timer_two_flag && count == 16'h0000)
    else $error("timer two flag not set at zero");
  c_t2_pulse_flag: cover property (@(posedge clk_sys) disable iff (!rstn)
    pulse_mode && hit);

endmodule
`default_nettype wire

// ==== ttsr_buf.sv ====
// Two-entry buffer with valid and ready on both sides for received bytes.
// Assumes the source holds its data while valid is high and ready is low.
`timescale 1ns/10ps
`default_nettype none
module ttsr_buf (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic      [7:0] out_data
);

  logic       spare_v_reg;
  logic [7:0] spare_reg;
  logic       push;
  logic       pop;

  assign push     = in_valid & ~spare_v_reg;
  assign pop      = out_valid & out_ready;
  assign in_ready = ~spare_v_reg; // Full when the spare slot is taken

  // Head entry feeds the output, spare entry catches a word during a stall
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_valid   <= 1'b0;
      out_data    <= 8'h00;
      spare_v_reg <= 1'b0;
      spare_reg   <= 8'h00;
    end else if (spare_v_reg) begin
      if (pop) begin
        out_data    <= spare_reg;
        spare_v_reg <= 1'b0;
      end
    end else if (push) begin
      if (!out_valid || pop) begin
        out_data  <= in_data;
        out_valid <= 1'b1;
      end else begin
        spare_reg   <= in_data;
        spare_v_reg <= 1'b1;
      end
    end else if (pop) begin
      out_valid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== ttsr_top.sv ====
// Interval timer two and the 8-bit serial shifter it can pace.
// Assumes one-cycle bus strobes synchronous to clk_sys; flags and enables
// of other sources, and the peripheral control bits, come from outside.
`timescale 1ns/10ps
`default_nettype none
module ttsr_top (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       chip_sel,
  input  wire logic       bus_strobe,
  input  wire logic       read_not_write,
  input  wire logic [3:0] reg_sel,
  input  wire logic [7:0] d_in,
  output logic      [7:0] d_out,
  output logic            d_oe,
  input  wire logic [2:0] shift_mode,
  input  wire logic       t2_pulse_mode,
  input  wire logic       pulse_count_input,
  input  wire logic       pcr_clock_level,
  input  wire logic       pcr_clock_oe,
  input  wire logic       pcr_data_level,
  input  wire logic       pcr_data_oe,
  input  wire logic       shift_clock_line_in,
  output logic            shift_clock_line_out,
  output logic            shift_clock_line_oe,
  input  wire logic       shift_data_line_in,
  output logic            shift_data_line_out,
  output logic            shift_data_line_oe,
  input  wire logic       timer_irq_en,
  input  wire logic       shift_irq_en,
  output logic            timer_two_flag,
  output logic            shift_done_flag,
  output logic            interrupt_request_n,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready
);

  ttsr_pkg::ttsr_state_e state_reg;
  ttsr_pkg::ttsr_state_e state_next;
  logic [7:0]  serial_shift_data_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  rate_cnt_reg;
  logic        clk_int_reg;
  logic        data_int_reg;
  logic        ext_prev_reg;
  logic        capt_pend_reg;
  logic [7:0]  latch_lo;
  logic [15:0] t2_count;
  logic        t2_flag;
  logic        buf_ready;
  logic        is_out;
  logic        is_ext;
  logic        is_off;
  logic        access;
  logic        wr_acc;
  logic        rd_acc;
  logic        sr_acc;
  logic        running;
  logic        tick;
  logic        rise_evt;
  logic        fall_evt;
  logic        cnt_evt;
  logic        done_evt;
  logic        stop_evt;
  logic [7:0]  rx_byte;

  // Register decode on the documented select lines
  assign access = chip_sel & bus_strobe;
  assign wr_acc = access & ~read_not_write;
  assign rd_acc = access & read_not_write;
  assign sr_acc = access & (reg_sel == ttsr_pkg::TTSR_SHIFT_OFF);

  // Mode decoding
  assign is_out  = ttsr_pkg::ttsr_is_out(shift_mode);
  assign is_ext  = ttsr_pkg::ttsr_is_ext(shift_mode);
  assign is_off  = (shift_mode == ttsr_pkg::TTSR_SM_OFF);
  assign running = (state_reg == ttsr_pkg::TTSR_ST_RUN);

  ttsr_timer u_timer (
    .clk_sys           (clk_sys),
    .rstn              (rstn),
    .pulse_mode        (t2_pulse_mode),
    .pulse_count_input (pulse_count_input),
    .wr_lo             (wr_acc && reg_sel == ttsr_pkg::TTSR_T2_LO_OFF),
    .wr_hi             (wr_acc && reg_sel == ttsr_pkg::TTSR_T2_HI_OFF),
    .rd_lo             (rd_acc && reg_sel == ttsr_pkg::TTSR_T2_LO_OFF),
    .wdata             (d_in),
    .latch_lo          (latch_lo),
    .count             (t2_count),
    .timer_two_flag    (t2_flag)
  );

  // Internal pacing: every cycle, or each time the low-latch count runs out
  assign tick = running && (!ttsr_pkg::ttsr_is_t2(shift_mode)
                            || rate_cnt_reg == 8'h00);

  // Shift clock edges: internal toggle or the sampled external line
  always_comb begin
    if (is_ext) begin
      rise_evt = shift_clock_line_in & ~ext_prev_reg;
      fall_evt = ~shift_clock_line_in & ext_prev_reg;
    end else begin
      rise_evt = tick & ~clk_int_reg;
      fall_evt = tick & clk_int_reg;
    end
  end

  // Output modes count at the rising edge, input modes at capture
  assign cnt_evt  = is_off ? 1'b0 : (is_out ? rise_evt : capt_pend_reg);
  assign done_evt = cnt_evt && bit_cnt_reg == ttsr_pkg::TTSR_LAST_BIT
                    && shift_mode != ttsr_pkg::TTSR_SM_OUT_FR;
  assign stop_evt = done_evt && !is_ext;
  assign rx_byte  = {serial_shift_data_reg[6:0], shift_data_line_in};

  // Sequencer: access requests a transfer, input modes wait for buffer room
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ttsr_pkg::TTSR_ST_IDLE: begin
        if (sr_acc && !is_off && !is_ext) begin
          state_next = ttsr_pkg::TTSR_ST_WAIT;
        end
      end
      ttsr_pkg::TTSR_ST_WAIT: begin
        if (is_off || is_ext) begin
          state_next = ttsr_pkg::TTSR_ST_IDLE;
        end else if (is_out || buf_ready) begin
          state_next = ttsr_pkg::TTSR_ST_RUN;
        end
      end
      ttsr_pkg::TTSR_ST_RUN: begin
        if (is_off || is_ext) begin
          state_next = ttsr_pkg::TTSR_ST_IDLE;
        end else if (sr_acc) begin
          state_next = ttsr_pkg::TTSR_ST_WAIT;
        end else if (stop_evt) begin
          state_next = ttsr_pkg::TTSR_ST_IDLE;
        end
      end
      default: state_next = ttsr_pkg::TTSR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ttsr_pkg::TTSR_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Rate counter reloads from the low timer latch
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rate_cnt_reg <= ttsr_pkg::TTSR_LATCH_RST;
    end else if (!running || rate_cnt_reg == 8'h00) begin
      rate_cnt_reg <= latch_lo;
    end else begin
      rate_cnt_reg <= rate_cnt_reg - 8'h01;
    end
  end

  // Internal shift clock idles high and toggles on each tick, except a fall that coincides with an input-mode stop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clk_int_reg  <= 1'b1;
      ext_prev_reg <= 1'b1;
    end else begin
      ext_prev_reg <= shift_clock_line_in;
      if (!running) begin
        clk_int_reg <= 1'b1;
      end else if (tick && !(fall_evt && stop_evt)) begin // No ninth fall at input stop
        clk_int_reg <= ~clk_int_reg;
      end
    end
  end

  // Capture waits one cycle after the rising clock edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      capt_pend_reg <= 1'b0;
    end else begin
      capt_pend_reg <= rise_evt && !is_out && !is_off;
    end
  end

  // Shift data: host write wins, else rotate out or shift in
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serial_shift_data_reg <= ttsr_pkg::TTSR_SHIFT_RST;
      data_int_reg          <= 1'b1;
    end else if (sr_acc && wr_acc) begin
      serial_shift_data_reg <= d_in;
    end else if (is_out && fall_evt) begin
      data_int_reg          <= serial_shift_data_reg[7];
      serial_shift_data_reg <= {serial_shift_data_reg[6:0],
                                serial_shift_data_reg[7]};
    end else if (!is_out && capt_pend_reg) begin
      serial_shift_data_reg <= rx_byte;
    end
  end

  // Modulo-8 bit counter, restarted by any shift register access
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_reg <= ttsr_pkg::TTSR_FIRST_BIT;
    end else if (sr_acc || is_off) begin
      bit_cnt_reg <= ttsr_pkg::TTSR_FIRST_BIT;
    end else if (cnt_evt) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Done flag: set wins over the access clear, held low when disabled
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shift_done_flag <= 1'b0;
    end else if (is_off) begin
      shift_done_flag <= 1'b0;
    end else if (done_evt) begin
      shift_done_flag <= 1'b1;
    end else if (sr_acc) begin
      shift_done_flag <= 1'b0;
    end
  end

  ttsr_buf u_buf (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (done_evt && !is_out),
    .in_ready  (buf_ready),
    .in_data   (rx_byte),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // Line drivers: peripheral control when disabled, shifter otherwise
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shift_clock_line_out <= 1'b1;
      shift_clock_line_oe  <= 1'b0;
      shift_data_line_out  <= 1'b1;
      shift_data_line_oe   <= 1'b0;
    end else if (is_off) begin
      shift_clock_line_out <= pcr_clock_level;
      shift_clock_line_oe  <= pcr_clock_oe;
      shift_data_line_out  <= pcr_data_level;
      shift_data_line_oe   <= pcr_data_oe;
    end else begin
      shift_clock_line_out <= clk_int_reg;
      shift_clock_line_oe  <= !is_ext;
      shift_data_line_out  <= data_int_reg;
      shift_data_line_oe   <= is_out;
    end
  end

  // Flag and request outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_two_flag      <= 1'b0;
      interrupt_request_n <= 1'b1;
    end else begin
      timer_two_flag      <= t2_flag;
      interrupt_request_n <= !((t2_flag && timer_irq_en)
                               || (shift_done_flag && shift_irq_en));
    end
  end

  // Read data answered in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      d_out <= ttsr_pkg::TTSR_READ_NONE;
      d_oe  <= 1'b0;
    end else begin
      d_oe <= rd_acc;
      if (rd_acc) begin
        case (reg_sel)
          ttsr_pkg::TTSR_T2_LO_OFF: d_out <= t2_count[7:0];
          ttsr_pkg::TTSR_T2_HI_OFF: d_out <= t2_count[15:8];
          ttsr_pkg::TTSR_SHIFT_OFF: d_out <= serial_shift_data_reg;
          default:                  d_out <= ttsr_pkg::TTSR_READ_NONE;
        endcase
      end
    end
  end

  // Checks on the shifter
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_off_no_done: assert property (is_off |=> !shift_done_flag)
    else $error("done flag not held low while disabled");
  a_tx_msb_rot: assert property ((is_out && fall_evt && !(sr_acc && wr_acc)) |=>
    (data_int_reg == $past(serial_shift_data_reg[7])
     && serial_shift_data_reg[0] == $past(serial_shift_data_reg[7])))
    else $error("shift out not msb first with rotation");
  a_rx_lsb_in: assert property ((!is_out && capt_pend_reg && !(sr_acc && wr_acc)) |=>
    serial_shift_data_reg == $past(rx_byte))
    else $error("shift in did not enter at bit 0");
  a_capt_delay: assert property ((rise_evt && !is_out && !is_off) |=> capt_pend_reg)
    else $error("capture not one cycle after rising edge");
  a_acc_clear: assert property ((sr_acc && !done_evt && !is_off) |=> !shift_done_flag)
    else $error("access did not clear done flag");
  a_free_no_done: assert property ((shift_mode == ttsr_pkg::TTSR_SM_OUT_FR
    && !shift_done_flag && !is_off) |=> !shift_done_flag)
    else $error("free-running mode raised done flag");
  a_stop_after8: assert property ((stop_evt && !sr_acc && !is_ext) |=>
    (state_reg == ttsr_pkg::TTSR_ST_IDLE) [*2])
    else $error("shifter did not stop after eight bits");
  a_ext_input: assert property ((is_ext && !is_off) |=> !shift_clock_line_oe)
    else $error("clock line driven in external mode");
  a_cnt_wrap: assert property ((cnt_evt && bit_cnt_reg == ttsr_pkg::TTSR_LAST_BIT
    && !sr_acc) |=> bit_cnt_reg == ttsr_pkg::TTSR_FIRST_BIT)
    else $error("bit counter not modulo eight");
  a_done_set: assert property (done_evt && !is_off |=> shift_done_flag ##1
    !interrupt_request_n || !shift_irq_en || !shift_done_flag)
    else $error("done flag or request missing after eight bits");

  c_in_t2_done: cover property (shift_mode == ttsr_pkg::TTSR_SM_IN_T2 && done_evt);
  c_out_sys_done: cover property (shift_mode == ttsr_pkg::TTSR_SM_OUT_SYS && done_evt);
  c_ext_rx_stall: cover property (rx_valid && !rx_ready && !buf_ready);

endmodule
`default_nettype wire

// ==== ttsr_peer.sv ====
// Serial peer for the shifter: captures data on rising clock edges and
// sends a byte msb first. Assumes the bench resolves the clock and data wires.
`timescale 1ns/10ps
`default_nettype none
module ttsr_peer (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clk_line,
  input  wire logic       data_line,
  input  wire logic       tx_en,
  input  wire logic [7:0] tx_byte,
  input  wire logic       ext_go,
  output logic            clk_out,
  output logic            data_out,
  output logic            data_oe,
  output logic      [7:0] rx_byte
);
  logic       clk_q;
  logic       fall;
  logic [2:0] k;
  logic [4:0] h;
  logic [1:0] p;

  // Next bit appears at each falling edge and holds until the next one
  assign fall     = clk_q & ~clk_line;
  assign data_oe  = tx_en;
  assign data_out = tx_byte[3'h0 - k - {2'h0, fall}];

  // Edge tracking, bit count and msb-first capture
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clk_q   <= 1'b1;
      k       <= 3'h0;
      rx_byte <= 8'h00;
    end else begin
      clk_q <= clk_line;
      if (!tx_en) begin
        k <= 3'h0;
      end else if (fall) begin
        k <= k + 3'h1;
      end
      if (clk_line && !clk_q) begin
        rx_byte <= {rx_byte[6:0], data_line};
      end
    end
  end

  // Eight clock pulses of eight cycles each; the clock rests high between bursts
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      h       <= 5'h00;
      p       <= 2'h0;
      clk_out <= 1'b1;
    end else if (ext_go) begin
      h <= 5'h10;
      p <= 2'h0;
    end else if (h != 5'h00) begin
      p <= p + 2'h1;
      if (p == 2'h3) begin
        clk_out <= ~clk_out;
        h       <= h - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_timer_two_and_shift_register.sv ====
// Self-checking bench for timer two and the serial shifter.
// Assumes the design files and the serial peer model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_timer_two_and_shift_register;
  logic       clk_sys = 1'b0, rstn = 1'b0, chip_sel = 1'b0, bus_strobe = 1'b0, rnw = 1'b1;
  logic       t2_pulse = 1'b0, pulse_in = 1'b1, rx_ready = 1'b0, pcr_ck = 1'b1, pcr_oe = 1'b0;
  logic       t2_ien = 1'b0, sh_ien = 1'b0, tx_en = 1'b0, ext_go = 1'b0, fl = 1'b0;
  logic [3:0] reg_sel = 4'h0;
  logic [2:0] mode = 3'h0;
  logic [7:0] d_in = 8'h00, tx_byte = 8'h00, rd, d_out, rx_data, prx;
  logic       d_oe, ck_o, ck_oe, dt_o, dt_oe, t2f, sdf, irq_n, rx_valid, p_ck, p_dt, p_oe;
  logic       ck_line, dt_line;
  int         n_fail = 0, compares = 0;

  // Wire levels; an undriven data line toggles every cycle
  assign ck_line = ck_oe ? ck_o : p_ck;
  assign dt_line = dt_oe ? dt_o : (p_oe ? p_dt : fl);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) fl <= ~fl;

  ttsr_top uut (
    .clk_sys(clk_sys), .rstn(rstn), .chip_sel(chip_sel), .bus_strobe(bus_strobe),
    .read_not_write(rnw), .reg_sel(reg_sel), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
    .shift_mode(mode), .t2_pulse_mode(t2_pulse), .pulse_count_input(pulse_in),
    .pcr_clock_level(pcr_ck), .pcr_clock_oe(pcr_oe), .pcr_data_level(~pcr_ck),
    .pcr_data_oe(pcr_oe), .shift_clock_line_in(ck_line), .shift_clock_line_out(ck_o),
    .shift_clock_line_oe(ck_oe), .shift_data_line_in(dt_line), .shift_data_line_out(dt_o),
    .shift_data_line_oe(dt_oe), .timer_irq_en(t2_ien), .shift_irq_en(sh_ien),
    .timer_two_flag(t2f), .shift_done_flag(sdf), .interrupt_request_n(irq_n),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
  ttsr_peer peer (
    .clk_sys(clk_sys), .rstn(rstn), .clk_line(ck_line), .data_line(dt_line), .tx_en(tx_en),
    .tx_byte(tx_byte), .ext_go(ext_go), .clk_out(p_ck), .data_out(p_dt), .data_oe(p_oe),
    .rx_byte(prx));

  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One register access; read data is taken the cycle after the strobe
  task acc(input logic r, input logic [3:0] a, input logic [7:0] wd);
    @(posedge clk_sys);
    chip_sel <= 1'b1;
    bus_strobe <= 1'b1;
    rnw <= r;
    reg_sel <= a;
    d_in <= wd;
    @(posedge clk_sys);
    bus_strobe <= 1'b0;
    #1 rd = d_out;
  endtask

  // Bounded wait for a flag: 0 timer flag, 1 shift done
  task wt(input int w);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      #1;
      if ((w == 0 && t2f === 1'b1) || (w == 1 && sdf === 1'b1)) break;
    end
    if (i == 400) begin
      chk("flag wait", 16'h0, 16'h1);
      test_done;
    end
  endtask

  task go;
    @(posedge clk_sys);
    ext_go <= 1'b1;
    @(posedge clk_sys);
    ext_go <= 1'b0;
  endtask

  // Falling pulses, each held low across two clock edges
  task pls(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pulse_in <= 1'b0;
      repeat (2) @(posedge clk_sys);
      pulse_in <= 1'b1;
      repeat (2) @(posedge clk_sys);
    end
    #1;
  endtask

  task timer_shot;
    t2_ien <= 1'b1;
    acc(0, 4'h8, 8'h02);
    acc(0, 4'h9, 8'h00);
    wt(0);
    chk("timer flag", t2f, 1);
    @(posedge clk_sys);
    #1 chk("irq timer", irq_n, 0);
    acc(1, 4'h9, 8'h00);
    chk("wrap high", rd, 8'hff);
    acc(1, 4'h8, 8'h00);
    repeat (20) @(posedge clk_sys);
    #1 chk("flag cleared", t2f, 0);
    acc(0, 4'h9, 8'h00);
    wt(0);
    chk("flag rearmed", t2f, 1);
  endtask

  task timer_pulse;
    t2_pulse <= 1'b1;
    t2_ien <= 1'b0;
    acc(0, 4'h8, 8'h03);
    acc(0, 4'h9, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk("load clears", t2f, 0);
    pls(2);
    chk("before zero", t2f, 0);
    pls(1);
    chk("at zero", t2f, 1);
    pls(1);
    acc(1, 4'h9, 8'h00);
    chk("past zero", rd, 8'hff);
  endtask

  task shift_off;
    pcr_oe <= 1'b1;
    pcr_ck <= 1'b0;
    sh_ien <= 1'b1;
    acc(0, 4'ha, 8'h5a);
    acc(1, 4'ha, 8'h00);
    chk("shift reg", rd, 8'h5a);
    chk("lines", {ck_oe, ck_o, dt_oe, dt_o, sdf}, 5'b10110);
    acc(1, 4'h3, 8'h00);
    chk("unmapped", rd, 8'h00);
    chk("read enable", d_oe, 1);
    pcr_ck <= 1'b1;
  endtask

  task shout(input logic [2:0] m, input logic [7:0] b);
    mode <= m;
    tx_en <= 1'b0;
    acc(0, 4'ha, b);
    if (m == 3'h7) go;
    wt(1);
    repeat (2) @(posedge clk_sys); // Line lags one cycle, peer samples one later
    #1 chk("peer byte", prx, b);
    chk("data hold", {ck_line, dt_line}, {1'b1, b[0]});
    acc(1, 4'ha, 8'h00);
    chk("rotated", rd, b);
    chk("done clear", sdf, 0);
    if (m == 3'h7) go;
    wt(1);
  endtask

  task shin(input logic [2:0] m, input logic [7:0] b);
    mode <= m;
    tx_byte <= b;
    tx_en <= 1'b1;
    acc(1, 4'ha, 8'h00);
    if (m == 3'h3) go;
    wt(1);
    @(posedge clk_sys); // Request output follows the flag by one cycle
    #1 chk("irq shift", irq_n, 0);
    acc(1, 4'ha, 8'h00);
    chk("shifted in", rd, b);
    if (m == 3'h3) go;
    wt(1);
    repeat (2) begin
      chk("rx word", {rx_valid, rx_data}, {1'b1, b});
      rx_ready <= 1'b1;
      @(posedge clk_sys);
      rx_ready <= 1'b0;
      @(posedge clk_sys);
      #1;
    end
    chk("rx empty", rx_valid, 0);
  endtask

  task free_run;
    mode <= 3'h4;
    tx_en <= 1'b0;
    acc(0, 4'ha, 8'h81);
    repeat (150) @(posedge clk_sys);
    #1 chk("no done", {sdf, irq_n}, 2'b01);
  endtask

  // Reset, then every mode in turn
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 chk("reset", {d_out, t2f, sdf, irq_n, rx_valid, ck_oe}, {8'h00, 5'b00100});
    rstn <= 1'b1;
    timer_shot;
    timer_pulse;
    shift_off;
    shin(3'h1, 8'h96);
    shin(3'h2, 8'h3a);
    shin(3'h3, 8'hc5);
    shout(3'h5, 8'ha3);
    shout(3'h6, 8'h5c);
    shout(3'h7, 8'h4e);
    free_run;
    test_done;
  end
endmodule
`default_nettype wire
